// ==== hdl/power_ctl_defines.vh ====
// Constants for the idle/doze power control block.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef POWER_CTL_DEFINES_VH
`define POWER_CTL_DEFINES_VH

// Register byte addresses on the AXI4-Lite bus.
`define ADDR_REGULATOR  4'h0
`define ADDR_DOZE_IDLE  4'h4
`define ADDR_STATUS     4'h8

// Field positions in the doze/idle control register.
`define BIT_IDLE_SELECT 7
`define BIT_SLOW_EN     6
`define BIT_RECOVER     5
`define BIT_SLOW_RET    4

// Reset values.
`define RST_REG_MODE    2'h1
`define RST_DOZE_IDLE   8'h00

// Regulator mode encodings.
`define REG_MODE_LOWEST 2'h3
`define REG_MODE_LOW    2'h2
`define REG_MODE_NORMAL 2'h1
`define REG_MODE_HIGH   2'h0

// Power states.
`define PST_RUN   2'h0
`define PST_IDLE  2'h1
`define PST_SLEEP 2'h2

// AXI responses.
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hdl/doze_divider.v ====
// Doze ratio counter: one CPU cycle enable per 2^(n+1) peripheral cycles.
// Assumes periphTick is a one-cycle enable on mclk.
`default_nettype none
`include "power_ctl_defines.vh"

module doze_divider (
	// Clock and reset.
	input  wire       mclk,
	input  wire       rst_n,
	// Control.
	input  wire       periphTick,
	input  wire       restart,
	input  wire [2:0] ratio,
	// Result.
	output reg        dozeTick_r
);

	// Counts peripheral cycles within one ratio period.
	reg  [7:0] count_r;
	// Last count of the period, 2^(n+1)-1.
	wire [7:0] lastCount = (8'h02 << ratio) - 8'h01;

	// The counter restarts on any change of the slowdown enable.
	always @(posedge mclk) begin
		if (!rst_n) begin
			count_r    <= 8'h00;
			dozeTick_r <= 1'b0;
		end else if (restart) begin
			count_r    <= 8'h00;
			dozeTick_r <= 1'b0;
		end else if (periphTick) begin
			dozeTick_r <= (count_r == lastCount);
			count_r    <= (count_r >= lastCount) ? 8'h00 : count_r + 8'h01;
		end else begin
			dozeTick_r <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== hdl/idle_doze_power_control.v ====
// Idle, sleep and doze control with regulator mode selection.
// Assumes CPU, interrupt logic and watchdog are on mclk; debug flag may be async.
//
// Summary of operation
// - Power-down with idle_select clear enters sleep.
// - Power-down with idle_select set enters idle.
// - System-clock peripherals run in idle, not sleep.
// - Clock output runs in idle when enabled (0).
// - Any enabled interrupt ends idle; idle_select unchanged.
// - Power-down again re-enters idle if selected.
// - Recover-on-irq wake from idle returns CPU to full speed.
// - Watchdog timeout in idle wakes, never resets.
// - Watchdog wake leaves slowdown enable untouched.
// - Two-bit regulator mode selects sleep regulator state.
// - Regulator mode resets to normal encoding.
// - Regulator register upper six bits read zero.
// - idle_select clears only on power-on/brown-out.
// - Slowdown enable gates CPU cycles by ratio.
// - Recover-on-irq clears slowdown at interrupt entry.
// - Slowdown-on-return sets slowdown at interrupt return.
// - Ratio code n gives one in 2^(n+1).
// - Bit 3 of doze register reads zero.
// - Slowdown writable by software and hardware.
// - Debugger forces full speed, stored bit kept.
// - Wake needs source enable, ignores global enable.
// - Global enable decides resume or vector after wake.
`default_nettype none
`include "power_ctl_defines.vh"

module idle_doze_power_control (
	// Clock and resets.
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       porBor,
	// CPU events.
	input  wire       powerDownExec,
	input  wire       irqEntry,
	input  wire       irqReturnExec,
	input  wire       globalIrqEnable,
	// Interrupt sources: enabled and pending requests.
	input  wire       irqPendingEnabled,
	// Watchdog and debug.
	input  wire       watchdogTimeout,
	input  wire       debugActive,
	input  wire       clkOutEnable_n,
	input  wire       periphTick,
	// AXI4-Lite write address.
	input  wire [3:0] s_axi_awaddr,
	input  wire       s_axi_awvalid,
	output reg        s_axi_awready,
	// AXI4-Lite write data.
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0] s_axi_wstrb,
	input  wire       s_axi_wvalid,
	output reg        s_axi_wready,
	// AXI4-Lite write response.
	output reg  [1:0] s_axi_bresp,
	output reg        s_axi_bvalid,
	input  wire       s_axi_bready,
	// AXI4-Lite read address.
	input  wire [3:0] s_axi_araddr,
	input  wire       s_axi_arvalid,
	output reg        s_axi_arready,
	// AXI4-Lite read data.
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0] s_axi_rresp,
	output reg        s_axi_rvalid,
	input  wire       s_axi_rready,
	// Power outputs.
	output reg        cpuClkEn_r,
	output reg        progMemEn_r,
	output reg        periphClkEn_r,
	output reg        clkOutEn_r,
	output reg        wdtResetOut_r,
	output reg        resumeVector_r,
	output reg        inIdle_r,
	output reg        inSleep_r,
	output reg  [1:0] regulatorMode_r
);

	// Debug flag comes from outside, so synchronise it.
	reg        dbgMeta_r;
	reg        dbgSync_r;

	// Register fields.
	reg        idleSelect_r;
	reg        slowEnable_r;
	reg        recoverOnIrq_r;
	reg        slowOnReturn_r;
	reg  [2:0] slowRatio_r;
	reg  [1:0] regMode_r;
	reg  [1:0] powerState_r;
	reg  [1:0] powerState_nxt;
	reg        slowEnable_nxt;
	reg        slowPrev_r;

	// Bus write capture.
	reg        awHeld_r;
	reg  [3:0] awAddr_r;
	reg        wHeld_r;
	reg  [31:0] wData_r;
	reg  [3:0] wStrb_r;
	wire       doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	wire       wrDoze  = doWrite && (awAddr_r == `ADDR_DOZE_IDLE) && wStrb_r[0];
	wire       wrReg   = doWrite && (awAddr_r == `ADDR_REGULATOR) && wStrb_r[0];
	wire       wdtWake = watchdogTimeout && (powerState_r == `PST_IDLE);
	wire       dozeTick;

	// Doze ratio divider on the peripheral instruction clock.
	doze_divider u_div (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.periphTick (periphTick),
		.restart    (slowPrev_r != slowEnable_r),
		.ratio      (slowRatio_r),
		.dozeTick_r (dozeTick)
	);

	// Two-stage synchroniser for the debugger flag.
	always @(posedge mclk) begin
		if (!rst_n) begin
			dbgMeta_r <= 1'b0;
			dbgSync_r <= 1'b0;
		end else begin
			dbgMeta_r <= debugActive;
			dbgSync_r <= dbgMeta_r;
		end
	end

	// Power state next value.
	always @* begin
		powerState_nxt = powerState_r;
		case (powerState_r)
			`PST_RUN: begin
				if (powerDownExec) begin
					// Full sleep or idle chosen by idle_select.
					powerState_nxt = idleSelect_r ? `PST_IDLE : `PST_SLEEP;
				end
			end
			`PST_IDLE: begin
				// Enabled interrupt or watchdog ends idle, regardless of global enable.
				if (irqPendingEnabled || wdtWake) begin
					powerState_nxt = `PST_RUN;
				end
			end
			`PST_SLEEP: begin
				// Sleep wake details lie outside; an enabled interrupt resumes.
				if (irqPendingEnabled) begin
					powerState_nxt = `PST_RUN;
				end
			end
			default: begin
				powerState_nxt = `PST_RUN;
			end
		endcase
	end

	// Slowdown enable next value: hardware set/clear beats software write.
	always @* begin
		slowEnable_nxt = slowEnable_r;
		if (wrDoze) begin
			slowEnable_nxt = wData_r[`BIT_SLOW_EN];
		end
		// Idle ends by interrupt: recover-on-irq restores full speed.
		if (powerState_r == `PST_IDLE && irqPendingEnabled && recoverOnIrq_r) begin
			slowEnable_nxt = 1'b0;
		end
		if (irqEntry && recoverOnIrq_r) begin
			slowEnable_nxt = 1'b0;
		end
		if (irqReturnExec && slowOnReturn_r) begin
			slowEnable_nxt = 1'b1;
		end
		// A watchdog wake adds no term here, so the bit stays.
	end

	// Control registers and power state.
	always @(posedge mclk) begin
		if (!rst_n) begin
			if (porBor) begin
				idleSelect_r <= 1'b0;
			end
			slowEnable_r   <= 1'b0;
			recoverOnIrq_r <= 1'b0;
			slowOnReturn_r <= 1'b0;
			slowRatio_r    <= 3'h0;
			regMode_r      <= `RST_REG_MODE;
			powerState_r   <= `PST_RUN;
			slowPrev_r     <= 1'b0;
		end else begin
			powerState_r <= powerState_nxt;
			slowEnable_r <= slowEnable_nxt;
			slowPrev_r   <= slowEnable_r;
			// Leaving idle never touches idle_select.
			if (wrDoze) begin
				idleSelect_r   <= wData_r[`BIT_IDLE_SELECT];
				recoverOnIrq_r <= wData_r[`BIT_RECOVER];
				slowOnReturn_r <= wData_r[`BIT_SLOW_RET];
				slowRatio_r    <= wData_r[2:0];
			end
			if (wrReg) begin
				regMode_r <= wData_r[1:0];
			end
		end
	end

	// Clock gating and status outputs.
	always @(posedge mclk) begin
		if (!rst_n) begin
			cpuClkEn_r      <= 1'b0;
			progMemEn_r     <= 1'b0;
			periphClkEn_r   <= 1'b0;
			clkOutEn_r      <= 1'b0;
			wdtResetOut_r   <= 1'b0;
			resumeVector_r  <= 1'b0;
			inIdle_r        <= 1'b0;
			inSleep_r       <= 1'b0;
			regulatorMode_r <= `RST_REG_MODE;
		end else begin
			inIdle_r        <= (powerState_nxt == `PST_IDLE);
			inSleep_r       <= (powerState_nxt == `PST_SLEEP);
			regulatorMode_r <= regMode_r;
			// CPU runs only when awake; doze gates cycles unless debug overrides.
			if (powerState_nxt != `PST_RUN) begin
				cpuClkEn_r <= 1'b0;
			end else if (slowEnable_nxt && !dbgSync_r) begin
				cpuClkEn_r <= dozeTick;
			end else begin
				// Full speed is one CPU cycle per peripheral instruction cycle.
				cpuClkEn_r <= periphTick;
			end
			progMemEn_r   <= (powerState_nxt == `PST_RUN);
			periphClkEn_r <= (powerState_nxt != `PST_SLEEP);
			clkOutEn_r    <= !clkOutEnable_n && (powerState_nxt != `PST_SLEEP);
			// Watchdog resets only when not idle.
			wdtResetOut_r <= watchdogTimeout && (powerState_r != `PST_IDLE);
			// On wake by interrupt, vector only when global enable is set.
			resumeVector_r <= (powerState_r != `PST_RUN) && (powerState_nxt == `PST_RUN)
				&& irqPendingEnabled && globalIrqEnable;
		end
	end

	// AXI write channel: address and data in either order, then response.
	always @(posedge mclk) begin
		if (!rst_n) begin
			awHeld_r      <= 1'b0;
			wHeld_r       <= 1'b0;
			awAddr_r      <= 4'h0;
			wData_r       <= 32'h00000000;
			wStrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_r     <= 1'b0;
				wHeld_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr_r == `ADDR_DOZE_IDLE || awAddr_r == `ADDR_REGULATOR)
					? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI read channel: one cycle to take the address, then data.
	always @(posedge mclk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				case (s_axi_araddr)
					`ADDR_REGULATOR: begin
						s_axi_rdata <= {30'h00000000, regMode_r};
					end
					`ADDR_DOZE_IDLE: begin
						s_axi_rdata <= {24'h000000, idleSelect_r, slowEnable_r,
							recoverOnIrq_r, slowOnReturn_r, 1'b0, slowRatio_r};
					end
					`ADDR_STATUS: begin
						s_axi_rdata <= {29'h00000000, dbgSync_r, powerState_r};
					end
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ==== test/power_ctl_chk.sv ====
// Assertion checker for the idle/doze power control block.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module power_ctl_chk (
	// Clock and reset.
	input wire logic       mclk,
	input wire logic       rst_n,
	// Inputs from CPU, interrupt and watchdog.
	input wire logic       powerDownExec,
	input wire logic       irqPendingEnabled,
	input wire logic       watchdogTimeout,
	input wire logic       globalIrqEnable,
	input wire logic       clkOutEnable_n,
	// Power outputs.
	input wire logic       cpuClkEn_r,
	input wire logic       progMemEn_r,
	input wire logic       periphClkEn_r,
	input wire logic       clkOutEn_r,
	input wire logic       wdtResetOut_r,
	input wire logic       resumeVector_r,
	input wire logic       inIdle_r,
	input wire logic       inSleep_r,
	input wire logic [1:0] regulatorMode_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Idle is left a few cycles after its cause.
	sequence sLeftIdle;
		##[1:4] !inIdle_r;
	endsequence
	// Wake request by a newly pending interrupt while idle.
	sequence sIrqInIdle;
		inIdle_r && $rose(irqPendingEnabled);
	endsequence
	chk_power_down: assert property (powerDownExec |-> ##[1:3] (inIdle_r || inSleep_r))
		else $error("power-down did not stop the CPU");
	chk_idle_halts: assert property (inIdle_r |-> !cpuClkEn_r && !progMemEn_r && periphClkEn_r)
		else $error("idle gating wrong");
	chk_sleep_stops: assert property (inSleep_r |-> !periphClkEn_r)
		else $error("peripheral clock runs in sleep");
	chk_clock_output_pin_idle: assert property (inIdle_r && !clkOutEnable_n |-> clkOutEn_r)
		else $error("clock output stopped in idle");
	chk_irq_wake: assert property (inIdle_r && irqPendingEnabled |-> sLeftIdle)
		else $error("interrupt did not end idle");
	chk_wdt_wake: assert property (inIdle_r && watchdogTimeout |-> sLeftIdle)
		else $error("watchdog did not wake idle");
	chk_wdt_noreset: assert property (inIdle_r && watchdogTimeout |-> !wdtResetOut_r [*3])
		else $error("watchdog reset in idle");
	chk_vector_gie: assert property (sIrqInIdle ##0 globalIrqEnable |-> ##[1:4] resumeVector_r)
		else $error("no vector after wake");
	chk_no_vector: assert property (sIrqInIdle ##0 !globalIrqEnable |-> !resumeVector_r [*4])
		else $error("vector with global enable clear");
	chk_reg_reset: assert property ($rose(rst_n) |-> regulatorMode_r == 2'h1)
		else $error("regulator mode reset value wrong");
endmodule
bind idle_doze_power_control power_ctl_chk chk (.*);
`default_nettype wire

// ==== test/cpu_side_model.sv ====
// Model of the CPU side: makes the peripheral instruction-cycle enable.
// Assumes one clock; DIV sets how many mclk cycles one instruction cycle takes.
`default_nettype none
module cpu_side_model #(
	parameter int DIV = 4
) (
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst_n,
	// One-cycle enable every DIV cycles.
	output var  logic periphTick
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// Counts mclk cycles and pulses at the end of each instruction cycle.
	always @(posedge mclk) begin
		cnt <= (!rst_n || cnt == DIV - 1) ? 0 : cnt + 1;
		periphTick <= rst_n && cnt == DIV - 1;
	end
endmodule
`default_nettype wire

// ==== test/tb_idle_doze_power_control.sv ====
// Self-checking bench for the idle/doze power control block.
// Assumes the CPU-side model gives a peripheral tick every 4 cycles.
`default_nettype none
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_idle_doze_power_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_n = 0, porBor = 1, powerDownExec = 0, irqEntry = 0;
	logic irqReturnExec = 0, globalIrqEnable = 0, irqPendingEnabled = 0;
	logic watchdogTimeout = 0, debugActive = 0, clkOutEnable_n = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
	logic s_axi_arvalid = 0, s_axi_rready = 1;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, regulatorMode_r, rsp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic cpuClkEn_r, progMemEn_r, periphClkEn_r, clkOutEn_r, wdtResetOut_r;
	logic resumeVector_r, inIdle_r, inSleep_r;
	wire logic periphTick;
	int err_count = 0, compares = 0, cycles = 0;
	idle_doze_power_control uut (.*);
	cpu_side_model #(.DIV(4)) model (.mclk(mclk), .rst_n(rst_n), .periphTick(periphTick));
	always #20 mclk = ~mclk;
	// Cuts a hang short.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Write one word; holds each channel until taken.
	task axWr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			cyc(1);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
	endtask
	// Read one word into rd and rsp.
	task axRd(input logic [3:0] a);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		do begin
			cyc(1);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata; rsp = s_axi_rresp;
	endtask
	// One-cycle pulse: 0 power-down, 1 watchdog, 2 entry, 3 return.
	task pulse(input int w);
		powerDownExec <= w == 0; watchdogTimeout <= w == 1;
		irqEntry <= w == 2; irqReturnExec <= w == 3;
		cyc(1);
		{powerDownExec, watchdogTimeout, irqEntry, irqReturnExec} <= 4'h0;
		cyc(5);
	endtask
	task irqWake;
		irqPendingEnabled <= 1;
		cyc(5);
		irqPendingEnabled <= 0;
		cyc(2);
	endtask
	task doReset(input logic p);
		porBor <= p; rst_n <= 0;
		cyc(10);
		rst_n <= 1; porBor <= 0;
		cyc(1);
	endtask
	// Cycles between two CPU enables.
	task period(output int p);
		p = 0;
		while (cpuClkEn_r !== 1'b1 && p < 3000) begin cyc(1); p++; end
		p = 1; cyc(1);
		while (cpuClkEn_r !== 1'b1 && p < 3000) begin cyc(1); p++; end
	endtask
	task t_regs;
		axRd(4'h0); `CHK("mode rst", 32'h1, rd)
		axRd(4'hc); `CHK("unmapped", 2'h2, rsp)
		for (int i = 0; i < 4; i++) begin
			axWr(4'h0, 32'hfc | i); axRd(4'h0); `CHK("mode rd", 32'(i), rd)
			`CHK("mode out", 2'(i), regulatorMode_r)
		end
		axWr(4'h4, 32'hff); axRd(4'h4); `CHK("doze rd", 32'hf7, rd)
	endtask
	task t_doze;
		int p;
		for (int r = 0; r < 4; r++) begin
			axWr(4'h4, 32'h40 | r); period(p); period(p);
			`CHK("doze period", 4 * (2 << r), p)
		end
		debugActive <= 1; cyc(4); period(p); period(p); `CHK("dbg period", 4, p)
		debugActive <= 0; axRd(4'h4); `CHK("dbg kept", 32'h43, rd)
		axWr(4'h4, 32'h0); period(p); period(p); `CHK("full period", 4, p)
		axWr(4'h4, 32'h61); pulse(2); axRd(4'h4); `CHK("entry clr", 32'h21, rd)
		axWr(4'h4, 32'h41); pulse(2); axRd(4'h4); `CHK("entry keep", 32'h41, rd)
		axWr(4'h4, 32'h11); pulse(3); axRd(4'h4); `CHK("ret set", 32'h51, rd)
		axWr(4'h4, 32'h01); pulse(3); axRd(4'h4); `CHK("ret keep", 32'h01, rd)
	endtask
	task t_idle;
		axWr(4'h4, 32'he0); pulse(0); `CHK("idle", 1'b1, inIdle_r)
		`CHK("idle periph", 1'b1, periphClkEn_r)
		`CHK("idle clock_output_pin", 1'b1, clkOutEn_r)
		pulse(1); `CHK("wdt wake", 1'b0, inIdle_r)
		`CHK("wdt rst", 1'b0, wdtResetOut_r)
		axRd(4'h4); `CHK("wdt keeps", 32'he0, rd)
		pulse(0); `CHK("re-idle", 1'b1, inIdle_r)
		irqWake; `CHK("irq wake", 1'b0, inIdle_r)
		axRd(4'h4); `CHK("irq slow", 32'ha0, rd)
		globalIrqEnable <= 1; pulse(0); irqWake; `CHK("gie wake", 1'b0, inIdle_r)
		axWr(4'h4, 32'h0); pulse(0); `CHK("sleep", 1'b1, inSleep_r)
		`CHK("sleep periph", 1'b0, periphClkEn_r)
		irqWake; `CHK("sleep wake", 1'b0, inSleep_r)
		globalIrqEnable <= 0;
	endtask
	task t_reset;
		axWr(4'h4, 32'h80); axWr(4'h0, 32'h3); doReset(0);
		axRd(4'h4); `CHK("warm idle", 32'h80, rd)
		axRd(4'h0); `CHK("warm mode", 32'h1, rd)
		doReset(1); axRd(4'h4); `CHK("cold idle", 32'h0, rd)
	endtask
	task wrap_up;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		doReset(1);
		t_regs();
		t_doze();
		t_idle();
		t_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
